// file: core/id_readout_pkg.sv
// Overview of operation
// - 90h: zero address, manufacturer then device byte
// - Start address one: device byte comes first
// - Bytes alternate until chip select rises
// - 92h: address and mode two bits per clock
// - 94h: four bits per clock, four dummies
// - Host sends mode bits with upper nibble ones
// - 92h refused in four-wire command mode
// - 94h refused in four-wire command mode
// - 90h works in both command modes
// - 4Bh: four dummy bytes, then 64 bits
// - Unique number fixed, per part, never writable
// - 4Bh only in single-line command mode
// - 9Fh: manufacturer, memory type, capacity bytes
// - 9Fh works in both command modes
// - 5Ah: address, eight dummies, data at 40th
// - 5Ah: upper address zero, low byte indexes
// - Power-down ignores every identification read
// - Header points to nine-dword first table
package id_readout_pkg;

	// Opcodes
	localparam logic [7:0] OP_ID_READ = 8'h90;
	localparam logic [7:0] OP_ID_DUAL = 8'h92;
	localparam logic [7:0] OP_ID_QUAD = 8'h94;
	localparam logic [7:0] OP_UNIQUE  = 8'h4b;
	localparam logic [7:0] OP_STD_ID  = 8'h9f;
	localparam logic [7:0] OP_PARAM   = 8'h5a;

	// Lane counts per clock
	localparam logic [2:0] LANES_1 = 3'h1;
	localparam logic [2:0] LANES_2 = 3'h2;
	localparam logic [2:0] LANES_4 = 3'h4;

	// Phase lengths in link clocks
	localparam logic [5:0] CMD_CLKS_1   = 6'h08;
	localparam logic [5:0] CMD_CLKS_4   = 6'h02;
	localparam logic [5:0] ADDR_CLKS_1  = 6'h18;
	localparam logic [5:0] ADDR_CLKS_2  = 6'h0c;
	localparam logic [5:0] ADDR_CLKS_4  = 6'h06;
	localparam logic [2:0] MODE_CLKS_2  = 3'h4;
	localparam logic [2:0] MODE_CLKS_4  = 3'h2;
	localparam logic [5:0] DUMMY_QUAD   = 6'h04;
	localparam logic [5:0] DUMMY_UNIQUE = 6'h20;
	localparam logic [5:0] DUMMY_PARAM  = 6'h08;

	// Content constants
	localparam logic [3:0] MODE_UPPER     = 4'hf;
	localparam logic [7:0] STD_ID_LAST    = 8'h02;
	localparam logic [7:0] FILL_BYTE      = 8'hff;
	localparam logic [7:0] HDR_BYTES      = 8'h10;
	localparam logic [7:0] TBL_PTR        = 8'h80;
	localparam logic [7:0] TBL_DWORDS     = 8'h09;
	localparam int         TBL_BYTES      = 4 * TBL_DWORDS;
	localparam logic [2:0] HOST_GAP_CLKS  = 3'h4;

	// Parameter-area header, signature first
	localparam logic [0:15][7:0] PARAM_HDR = {
		8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, FILL_BYTE,
		8'h00, 8'h00, 8'h01, TBL_DWORDS, TBL_PTR, 8'h00, 8'h00, FILL_BYTE
	};

	// Shape of one instruction after its opcode
	typedef struct packed {
		logic       ok;
		logic [5:0] addr_clks;
		logic [2:0] mode_clks;
		logic [5:0] dummy_clks;
		logic [2:0] in_lanes;
		logic [2:0] out_lanes;
	} shape_s;

	// Decode an opcode into its phase layout
	function automatic shape_s op_shape(input logic [7:0] op,
		input logic four_wire);
		shape_s s;
		s = '0;
		s.in_lanes = LANES_1;
		s.out_lanes = LANES_1;
		case (op)
			OP_ID_READ: begin
				s.ok = 1'b1;
				s.addr_clks = four_wire ? ADDR_CLKS_4 : ADDR_CLKS_1;
				s.in_lanes = four_wire ? LANES_4 : LANES_1;
				s.out_lanes = s.in_lanes;
			end
			OP_ID_DUAL: begin
				s.ok = !four_wire;
				s.addr_clks = ADDR_CLKS_2;
				s.mode_clks = MODE_CLKS_2;
				s.in_lanes = LANES_2;
				s.out_lanes = LANES_2;
			end
			OP_ID_QUAD: begin
				s.ok = !four_wire;
				s.addr_clks = ADDR_CLKS_4;
				s.mode_clks = MODE_CLKS_4;
				s.dummy_clks = DUMMY_QUAD;
				s.in_lanes = LANES_4;
				s.out_lanes = LANES_4;
			end
			OP_UNIQUE: begin
				s.ok = !four_wire;
				s.dummy_clks = DUMMY_UNIQUE;
			end
			OP_STD_ID: begin
				s.ok = 1'b1;
				s.out_lanes = four_wire ? LANES_4 : LANES_1;
			end
			OP_PARAM: begin
				s.ok = !four_wire;
				s.addr_clks = ADDR_CLKS_1;
				s.dummy_clks = DUMMY_PARAM;
			end
			default: s.ok = 1'b0;
		endcase
		return s;
	endfunction

	// Clocks between opcode and first output
	function automatic logic [5:0] pre_clks(input shape_s s);
		return 6'(s.addr_clks + 6'(s.mode_clks) + s.dummy_clks);
	endfunction

	// Shift lane bits in, most significant first
	function automatic logic [23:0] shift_in(input logic [23:0] sh,
		input logic [3:0] io, input logic [2:0] lanes, input logic sin);
		case (lanes)
			LANES_4: return {sh[19:0], io};
			LANES_2: return {sh[21:0], io[1:0]};
			default: return {sh[22:0], sin};
		endcase
	endfunction

endpackage

// file: core/flash_link_if.sv
`timescale 1ns/1ps
interface flash_link_if;
	logic       sclk;      // Link clock from host
	logic       cs_n;      // Chip select, low in frame
	logic [3:0] host_o;    // Host drive value
	logic [3:0] host_oe;   // Host drive enable
	logic [3:0] dev_o;     // Device drive value
	logic [3:0] dev_oe;    // Device drive enable
	logic [3:0] io;        // Resolved lane levels

	// Resolve each lane, pulled high when idle
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign io[i] = host_oe[i] ? host_o[i] :
			(dev_oe[i] ? dev_o[i] : 1'b1);
	end

	modport host (output sclk, output cs_n, output host_o,
		output host_oe, input io);
	modport device (input sclk, input cs_n, output dev_o,
		output dev_oe, input io);
endinterface

// file: core/id_store.sv
`timescale 1ns/1ps
module id_store
	import id_readout_pkg::*;
#(
	parameter logic [7:0]         MFR_CODE  = 8'h5c, // Arbitrary value
	parameter logic [7:0]         DEV_BYTE  = 8'h17, // Arbitrary value
	parameter logic [7:0]         MEM_TYPE  = 8'h40,
	parameter logic [7:0]         CAPACITY  = 8'h18,
	parameter logic [63:0]        UNIQUE_ID = 64'h0123_4567_89ab_cdef,
	parameter logic [0:35][7:0]   PARAM_TBL = {36{8'hff}}
) (
	input  wire logic [7:0] op,
	input  wire logic [7:0] start,
	input  wire logic [7:0] idx,
	output logic      [7:0] data
);
	logic [7:0] pa;   // Parameter-area byte address
	logic [7:0] toff; // Offset into first table

	// Select the byte for this opcode and position
	always_comb begin
		pa = 8'(start + idx);
		toff = 8'(pa - TBL_PTR);
		data = FILL_BYTE;
		case (op)
			OP_ID_READ, OP_ID_DUAL, OP_ID_QUAD: begin
				data = (start[0] ^ idx[0]) ? DEV_BYTE : MFR_CODE;
			end
			OP_UNIQUE: data = UNIQUE_ID[{~idx[2:0], 3'h0} +: 8];
			OP_STD_ID: begin
				if (idx == 8'h00) begin
					data = MFR_CODE;
				end else if (idx == 8'h01) begin
					data = MEM_TYPE;
				end else begin
					data = CAPACITY;
				end
			end
			OP_PARAM: begin
				if (pa < HDR_BYTES) begin
					data = PARAM_HDR[pa[3:0]];
				end else if (pa >= TBL_PTR && toff < 8'(TBL_BYTES)) begin
					data = PARAM_TBL[toff[5:0]];
				end
			end
			default: data = FILL_BYTE;
		endcase
	end
endmodule

// file: core/id_responder.sv
`timescale 1ns/1ps
module id_responder
	import id_readout_pkg::*;
#(
	parameter logic [7:0]         MFR_CODE  = 8'h5c, // Arbitrary value
	parameter logic [7:0]         DEV_BYTE  = 8'h17, // Arbitrary value
	parameter logic [7:0]         MEM_TYPE  = 8'h40,
	parameter logic [7:0]         CAPACITY  = 8'h18,
	parameter logic [63:0]        UNIQUE_ID = 64'h0123_4567_89ab_cdef,
	parameter logic [0:35][7:0]   PARAM_TBL = {36{8'hff}}
) (
	flash_link_if.device    link,
	input  wire logic       power_down,
	input  wire logic       four_wire_command_mode,
	output logic      [7:0] opcode_seen,
	output logic            refused,
	output logic            streaming
);
	// Instruction progress inside one frame
	typedef enum logic [1:0] {
		ST_CMD    = 2'b00,
		ST_PRE    = 2'b01,
		ST_OUT    = 2'b10,
		ST_IGNORE = 2'b11
	} dev_state_e;

	// Whole frame state, cleared while chip select is high
	typedef struct packed {
		dev_state_e  st;
		logic [23:0] sh;
		logic [5:0]  cnt;
		shape_s      shp;
		logic [7:0]  op;
		logic [7:0]  addr;
		logic [7:0]  idx;
		logic [2:0]  bitp;
	} dev_s;

	dev_s       q;          // Registered frame state
	dev_s       d;          // Next frame state
	shape_s     nshp;       // Shape of the opcode just received
	logic [5:0] cmd_clks;   // Opcode length for this mode
	logic [2:0] cmd_lanes;  // Opcode lanes for this mode
	logic [3:0] nbit;       // Output bit pointer plus lanes
	logic [7:0] cur_byte;   // Byte now being shifted out
	logic [7:0] byte_sh;    // Byte aligned to current bit
	logic [3:0] out_v;      // Lane values for next falling edge
	logic [3:0] out_e;      // Lane enables for next falling edge
	logic [3:0] dout_q;     // Driven lane values
	logic [3:0] doe_q;      // Driven lane enables
	logic [1:0] pd_q;       // Power-down synchroniser
	logic [1:0] fw_q;       // Command-mode synchroniser

	// Two-stage synchronisers onto the link clock; only the second
	// stage is read, so both levels must settle before the frame
	always_ff @(posedge link.sclk) begin
		pd_q <= {pd_q[0], power_down};
		fw_q <= {fw_q[0], four_wire_command_mode};
	end

	// Opcode width follows the command mode
	assign cmd_clks = fw_q[1] ? CMD_CLKS_4 : CMD_CLKS_1;
	assign cmd_lanes = fw_q[1] ? LANES_4 : LANES_1;

	// Byte lookup for the running instruction
	id_store #(
		.MFR_CODE  (MFR_CODE),
		.DEV_BYTE  (DEV_BYTE),
		.MEM_TYPE  (MEM_TYPE),
		.CAPACITY  (CAPACITY),
		.UNIQUE_ID (UNIQUE_ID),
		.PARAM_TBL (PARAM_TBL)
	) u_store (
		.op    (q.op),
		.start (q.addr),
		.idx   (q.idx),
		.data  (cur_byte)
	);

	// Next-state logic, evaluated for each rising link edge
	always_comb begin
		d = q;
		nshp = op_shape(q.sh[7:0], fw_q[1]);
		nbit = 4'(q.bitp) + 4'(q.shp.out_lanes);
		unique case (q.st)
			// Collect the opcode on one or four lanes
			ST_CMD: begin
				d.sh = shift_in(q.sh, link.io, cmd_lanes, link.io[0]);
				d.cnt = 6'(q.cnt + 6'h01);
				if (q.cnt == 6'(cmd_clks - 6'h01)) begin
					nshp = op_shape(d.sh[7:0], fw_q[1]);
					d.op = d.sh[7:0];
					d.shp = nshp;
					d.cnt = '0;
					d.idx = '0;
					d.bitp = '0;
					if (pd_q[1]) begin
						d.st = ST_IGNORE;
					end else if (!nshp.ok) begin
						d.st = ST_IGNORE;
					end else if (pre_clks(nshp) == 6'h00) begin
						d.st = ST_OUT;
					end else begin
						d.st = ST_PRE;
					end
				end
			end
			// Address, mode and dummy clocks
			ST_PRE: begin
				d.sh = shift_in(q.sh, link.io, q.shp.in_lanes,
					link.io[0]);
				d.cnt = 6'(q.cnt + 6'h01);
				// keep only the low address byte
				if (q.cnt == 6'(q.shp.addr_clks - 6'h01)) begin
					d.addr = d.sh[7:0];
				end
				// output starts after the last pre clock
				if (q.cnt == 6'(pre_clks(q.shp) - 6'h01)) begin
					d.st = ST_OUT;
				end
			end
			// Advance the output pointer by the lane count
			ST_OUT: begin
				d.bitp = nbit[2:0];
				if (nbit[3]) begin
					// run on until chip select rises
					if (q.op == OP_STD_ID && q.idx == STD_ID_LAST) begin
						d.idx = '0;
					end else begin
						d.idx = 8'(q.idx + 8'h01);
					end
				end
			end
			// Unsupported or blocked: wait for frame end
			ST_IGNORE: begin
				d.st = ST_IGNORE;
			end
		endcase
	end

	// Frame state; chip select high is the frame reset
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Lane mapping of the current output bits
	always_comb begin
		byte_sh = cur_byte << q.bitp;
		unique case (q.shp.out_lanes)
			LANES_4: begin
				out_v = byte_sh[7:4];
				out_e = 4'hf;
			end
			// two bits per clock, MSB on lane one
			LANES_2: begin
				out_v = {2'h0, byte_sh[7:6]};
				out_e = 4'h3;
			end
			default: begin
				out_v = {2'h0, byte_sh[7], 1'b0};
				out_e = 4'h2;
			end
		endcase
	end

	// Data changes on falling link edges; chip select rising clears it
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			dout_q <= '0;
			doe_q <= '0;
		end else if (q.st == ST_OUT) begin
			dout_q <= out_v;
			doe_q <= out_e;
		end else begin
			doe_q <= '0;
		end
	end

	// Link and status outputs
	assign link.dev_o = dout_q;
	assign link.dev_oe = doe_q;
	assign opcode_seen = q.op;
	assign refused = (q.st == ST_IGNORE);
	assign streaming = (q.st == ST_OUT);
endmodule

// file: core/id_requester.sv
`timescale 1ns/1ps
module id_requester
	import id_readout_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	flash_link_if.host      link,
	input  wire logic       start,
	input  wire logic [7:0] opcode,
	input  wire logic [23:0] address,
	input  wire logic [7:0] mode_bits,
	input  wire logic       four_wire_command_mode,
	input  wire logic [7:0] read_len,
	output logic            busy,
	output logic            refused,
	output logic            rd_valid,
	output logic [7:0]      rd_data
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_RUN  = 2'b01,
		H_GAP  = 2'b10
	} host_state_e;

	// Whole host state
	typedef struct packed {
		host_state_e st;
		logic        sclk;
		logic        cs_n;
		logic [3:0]  io_o;
		logic [3:0]  io_oe;
		logic [39:0] tx;
		logic [11:0] rise;
		shape_s      shp;
		logic        fw;
		logic [7:0]  rx;
		logic [2:0]  rxb;
		logic [7:0]  left;
		logic        rd_valid;
		logic [7:0]  rd_data;
		logic        refused;
		logic [3:0]  meta;
		logic [3:0]  sync;
		logic [2:0]  gap;
	} host_s;

	localparam host_s H_RST = '{st: H_IDLE, cs_n: 1'b1, default: '0};

	host_s       q;      // Registered state
	host_s       d;      // Next state
	shape_s      ns;     // Shape of requested opcode
	logic        drv;    // Set up lanes for the next rise
	logic [2:0]  ln;     // Lanes for the bit being sent
	logic [11:0] cmdc;   // Opcode clocks
	logic [11:0] sendc;  // Clocks with host driving
	logic [3:0]  nb;     // Receive bit count plus lanes
	logic [23:0] rxn;    // Receive shift result
	logic [23:0] atx;    // Address as sent

	// Sequencer: sclk is ref_clk divided by two
	always_comb begin
		d = q;
		d.rd_valid = 1'b0;
		d.refused = 1'b0;
		d.meta = link.io;
		d.sync = q.meta;
		drv = 1'b0;
		// Opcode clocks of the running frame, known before the case
		cmdc = q.fw ? 12'(CMD_CLKS_4) : 12'(CMD_CLKS_1);
		ns = op_shape(opcode, four_wire_command_mode);
		atx = (opcode == OP_PARAM) ? {16'h0, address[7:0]} :
			{23'h0, address[0]};
		rxn = shift_in({16'h0, q.rx}, q.sync, q.shp.out_lanes, q.sync[1]);
		nb = 4'(q.rxb) + 4'(q.shp.out_lanes);
		unique case (q.st)
			H_IDLE: begin
				if (start && ns.ok) begin
					d.tx = {opcode, atx, MODE_UPPER, mode_bits[3:0]};
					d.shp = ns;
					d.fw = four_wire_command_mode;
					d.cs_n = 1'b0;
					d.rise = '0;
					d.rxb = '0;
					d.left = (read_len == 8'h00) ? 8'h01 : read_len;
					d.st = H_RUN;
					drv = 1'b1;
				end else if (start) begin
					d.refused = 1'b1;
				end
			end
			H_RUN: begin
				if (q.sclk) begin
					d.sclk = 1'b0;
					drv = 1'b1;
				end else begin
					d.sclk = 1'b1;
					d.rise = 12'(q.rise + 12'h001);
					// Lane data is two sync stages behind the pins
					if (q.rise > 12'(pre_clks(q.shp)) + cmdc) begin
						d.rx = rxn[7:0];
						d.rxb = nb[2:0];
						if (nb[3]) begin
							d.rd_valid = 1'b1;
							d.rd_data = rxn[7:0];
							d.left = 8'(q.left - 8'h01);
							// end the stream by chip select
							if (q.left == 8'h01) begin
								d.st = H_GAP;
								d.cs_n = 1'b1;
								d.sclk = 1'b0;
								d.gap = '0;
							end
						end
					end
				end
			end
			H_GAP: begin
				d.io_oe = '0;
				d.gap = 3'(q.gap + 3'h1);
				if (q.gap == 3'(HOST_GAP_CLKS - 3'h1)) begin
					d.st = H_IDLE;
				end
			end
			default: d = H_RST;
		endcase
		// Present lanes for the coming rising edge
		cmdc = d.fw ? 12'(CMD_CLKS_4) : 12'(CMD_CLKS_1);
		sendc = cmdc + 12'(d.shp.addr_clks) + 12'(d.shp.mode_clks);
		ln = (d.rise < cmdc) ? (d.fw ? LANES_4 : LANES_1) :
			d.shp.in_lanes;
		if (drv) begin
			if (d.rise < sendc) begin
				d.io_o = (ln == LANES_4) ? d.tx[39:36] :
					((ln == LANES_2) ? {2'h0, d.tx[39:38]} :
					{3'h0, d.tx[39]});
				d.io_oe = (ln == LANES_4) ? 4'hf :
					((ln == LANES_2) ? 4'h3 : 4'h1);
				d.tx = d.tx << ln;
			end else begin
				d.io_oe = '0;
			end
		end
	end

	// Synchronous active-low reset
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			q <= H_RST;
		end else begin
			q <= d;
		end
	end

	assign link.sclk = q.sclk;
	assign link.cs_n = q.cs_n;
	assign link.host_o = q.io_o;
	assign link.host_oe = q.io_oe;
	assign busy = (q.st != H_IDLE);
	assign refused = q.refused;
	assign rd_valid = q.rd_valid;
	assign rd_data = q.rd_data;
endmodule

// file: testbench/id_link_props.sv
`timescale 1ns/1ps
module id_link_props (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic       sclk,
	input wire logic       cs_n,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_o,
	input wire logic [3:0] dev_oe,
	input wire logic [3:0] io
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	logic [7:0] rises_q;  // Link clock rises in this frame
	logic [7:0] op_q;     // Opcode gathered from lane 0
	logic       single_q; // Opcode came over one lane

	// Count link rises and capture a one-lane opcode
	always_ff @(posedge ref_clk) begin
		if (cs_n) begin
			rises_q <= 8'h00;
		end else if ($rose(sclk)) begin
			rises_q <= rises_q + 8'h01;
			if (rises_q < 8'h08) op_q <= {op_q[6:0], io[0]};
			if (rises_q == 8'h00) single_q <= (host_oe == 4'h1);
		end
	end

	// Clocks before the first output bit, one-lane opcodes
	function automatic logic [7:0] pre_of(input logic [7:0] op);
		case (op)
			8'h90: return 8'h20;
			8'h92: return 8'h18;
			8'h94: return 8'h14;
			8'h4b, 8'h5a: return 8'h28;
			8'h9f: return 8'h08;
			default: return 8'hff;
		endcase
	endfunction

	property p_lane_release;
		(dev_oe != 4'h0) |-> host_oe == 4'h0;
	endproperty
	a_lane_release: assert property (p_lane_release)
		else $error("host and device drive lanes together");

	property p_oe_clear;
		cs_n |-> dev_oe == 4'h0;
	endproperty
	a_oe_clear: assert property (p_oe_clear)
		else $error("device drives outside a frame");

	property p_sclk_idle;
		cs_n |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("link clock not low while deselected");

	property p_cs_gap;
		$rose(cs_n) |=> cs_n [*3];
	endproperty
	a_cs_gap: assert property (p_cs_gap)
		else $error("chip select gap too short");

	property p_out_on_fall;
		!cs_n && !$past(cs_n) && (dev_oe != 4'h0) &&
			($past(dev_oe) != 4'h0) && $changed(dev_o) |-> $fell(sclk);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("device data changed off a falling edge");

	property p_lane_set;
		dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf};
	endproperty
	a_lane_set: assert property (p_lane_set)
		else $error("device lane enables out of pattern");

	property p_first_out;
		single_q && $rose(dev_oe[1]) |-> rises_q == pre_of(op_q);
	endproperty
	a_first_out: assert property (p_first_out)
		else $error("first output bit at wrong clock");

	property p_stream_holds;
		!cs_n && ($past(dev_oe) != 4'h0) |-> dev_oe == $past(dev_oe);
	endproperty
	a_stream_holds: assert property (p_stream_holds)
		else $error("device output stopped inside frame");

	c_param: cover property (single_q && $rose(dev_oe[1]) && op_q == 8'h5a);
	c_quad: cover property (dev_oe == 4'hf);
	c_dual: cover property (dev_oe == 4'h3);
endmodule

// file: testbench/serial_flash_id_readout_tb.sv
`timescale 1ns/1ps
module serial_flash_id_readout_tb;
	import id_readout_pkg::*;
	localparam logic [7:0]  MFR = 8'h3a; // Arbitrary maker code
	localparam logic [7:0]  DEV = 8'hc5; // Arbitrary device byte
	localparam logic [7:0]  MEM = 8'h62; // Arbitrary memory type
	localparam logic [7:0]  CAP = 8'h19; // Arbitrary capacity
	localparam logic [63:0] UID = 64'hf0e1_d2c3_b4a5_9687;
	localparam logic [0:5][7:0] OPS = {OP_ID_READ, OP_ID_DUAL,
		OP_ID_QUAD, OP_UNIQUE, OP_STD_ID, OP_PARAM};
	localparam logic [0:3][7:0] SPI_ONLY = {OP_ID_DUAL, OP_ID_QUAD,
		OP_UNIQUE, OP_PARAM};

	logic        ref_clk, reset_n, start, four_wire, dev_fw, power_down;
	logic [7:0]  opcode, mode_bits, read_len, rd_data, dev_op;
	logic [23:0] address;
	logic        busy, refused, rd_valid, dev_refused, dev_streaming;
	logic [31:0] rng;          // Random state
	int          err_count;    // Mismatches
	int          total_checks; // Comparisons

	flash_link_if lnk();

	id_requester i_id_requester (.ref_clk(ref_clk), .reset_n(reset_n),
		.link(lnk), .start(start), .opcode(opcode), .address(address),
		.mode_bits(mode_bits), .four_wire_command_mode(four_wire),
		.read_len(read_len), .busy(busy), .refused(refused),
		.rd_valid(rd_valid), .rd_data(rd_data));

	id_responder #(.MFR_CODE(MFR), .DEV_BYTE(DEV), .MEM_TYPE(MEM),
		.CAPACITY(CAP), .UNIQUE_ID(UID)) i_id_responder (.link(lnk),
		.power_down(power_down), .four_wire_command_mode(dev_fw),
		.opcode_seen(dev_op), .refused(dev_refused),
		.streaming(dev_streaming));

	id_link_props i_id_link_props (.ref_clk(ref_clk), .reset_n(reset_n),
		.sclk(lnk.sclk), .cs_n(lnk.cs_n), .host_oe(lnk.host_oe),
		.dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe), .io(lnk.io));

	// Free-running system clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Next random word
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// Byte n of a read, worked out from the command
	function automatic logic [7:0] exp_byte(input logic [7:0] op,
		input logic [23:0] a, input int n);
		logic [7:0] i;
		i = a[7:0] + 8'(n);
		case (op)
			OP_UNIQUE: return UID[63 - 8 * (n % 8) -: 8];
			OP_STD_ID: return (n % 3 == 0) ? MFR : ((n % 3 == 1) ? MEM : CAP);
			OP_PARAM: return (i < HDR_BYTES) ? PARAM_HDR[i[3:0]] : FILL_BYTE;
			default: return (a[0] ^ n[0]) ? DEV : MFR;
		endcase
	endfunction

	// Byte comparison
	task automatic chk8(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Flag comparison
	task automatic chk1(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Issue one read and check what comes back
	task automatic run(input logic [7:0] op, input logic [23:0] a,
		input logic fw, input logic [7:0] len, input logic ok,
		input logic pd, input logic chk);
		logic [7:0] q[$];
		logic       seen_ref;
		logic       seen_str;
		logic [7:0] seen_op;
		int         k;
		seen_ref = 1'b0;
		seen_str = 1'b0;
		seen_op = 8'h00;
		@(posedge ref_clk);
		start <= 1'b1;
		opcode <= op;
		address <= a;
		read_len <= len;
		four_wire <= fw;
		rng = xorshift(rng);
		mode_bits <= {4'hf, rng[3:0]};
		@(posedge ref_clk);
		start <= 1'b0;
		@(negedge ref_clk);
		if (chk) begin
			chk1("refused", !ok, refused);
			chk1("busy", ok, busy);
		end
		for (k = 0; k < 4000 && busy === 1'b1; k++) begin
			if (dev_refused === 1'b1) seen_ref = 1'b1;
			if (dev_streaming === 1'b1) seen_str = 1'b1;
			if (lnk.cs_n === 1'b0 && dev_op !== 8'h00) seen_op = dev_op;
			@(negedge ref_clk);
			if (rd_valid === 1'b1) q.push_back(rd_data);
		end
		if (chk) begin
			k = ok ? ((len == 8'h00) ? 1 : int'(len)) : 0;
			chk8("byte count", 8'(k), 8'(q.size()));
			chk1("device refused", pd, seen_ref);
			chk1("device streaming", ok && !pd, seen_str);
			chk8("opcode seen", ok ? op : 8'h00, seen_op);
			for (k = 0; k < q.size(); k++) begin
				chk8("read byte", pd ? 8'hff : exp_byte(op, a, k), q[k]);
			end
		end
		$display("test op %h len %0d done", op, len);
	endtask

	// Counts, verdict, end of run
	task summarize;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Cut a hang short
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_count++;
		summarize();
	end

	// Main sequence
	initial begin
		logic [7:0]  op;
		logic [23:0] a;
		int          j;
		rng = 32'd32;
		err_count = 0;
		total_checks = 0;
		{start, four_wire, dev_fw, power_down, reset_n} = 5'h00;
		{opcode, mode_bits, read_len, address} = '0;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		run(OP_ID_READ, 24'h0, 0, 8'h05, 1, 0, 1);
		run(OP_ID_READ, 24'h1, 0, 8'h04, 1, 0, 1);
		run(OP_ID_DUAL, 24'h1, 0, 8'h06, 1, 0, 1);
		run(OP_ID_QUAD, 24'h0, 0, 8'h05, 1, 0, 1);
		run(OP_UNIQUE, 24'h0, 0, 8'h0a, 1, 0, 1);
		run(OP_STD_ID, 24'h0, 0, 8'h07, 1, 0, 1);
		run(OP_STD_ID, 24'h0, 0, 8'h00, 1, 0, 1);
		run(OP_PARAM, 24'h0a, 0, 8'h04, 1, 0, 1);
		run(OP_PARAM, 24'hfe, 0, 8'h04, 1, 0, 1);
		for (j = 0; j < 12; j++) begin
			rng = xorshift(rng);
			op = OPS[rng[2:0] % 3'd6];
			a = (op == OP_PARAM) ? {16'h0, rng[15:8]} : {23'h0, rng[16]};
			run(op, a, 0, 8'(1 + rng[23:20] % 4'd12), 1, 0, 1);
		end
		@(posedge ref_clk) dev_fw <= 1'b1;
		run(OP_STD_ID, 24'h0, 1, 8'h02, 1, 0, 0);
		run(OP_ID_READ, 24'h0, 1, 8'h04, 1, 0, 1);
		run(OP_ID_READ, 24'h1, 1, 8'h03, 1, 0, 1);
		run(OP_STD_ID, 24'h0, 1, 8'h06, 1, 0, 1);
		for (j = 0; j < 4; j++) begin
			run(SPI_ONLY[j], 24'h0, 1, 8'h02, 0, 0, 1);
		end
		@(posedge ref_clk);
		dev_fw <= 1'b0;
		power_down <= 1'b1;
		run(OP_STD_ID, 24'h0, 0, 8'h01, 1, 0, 0);
		run(OP_ID_READ, 24'h0, 0, 8'h02, 1, 1, 1);
		run(OP_PARAM, 24'h0, 0, 8'h02, 1, 1, 1);
		@(posedge ref_clk) power_down <= 1'b0;
		run(OP_STD_ID, 24'h0, 0, 8'h01, 1, 0, 0);
		run(OP_ID_QUAD, 24'h1, 0, 8'h03, 1, 0, 1);
		summarize();
	end
endmodule
